// file: include/ptc_pkg.sv
package ptc_pkg;

    localparam int CNT_W  = 10;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register indices on the plain register port
    localparam logic [2:0] REG_CLK_RUN  = 3'h0;
    localparam logic [2:0] REG_MODE_OUT = 3'h1;
    localparam logic [2:0] REG_CNT_LO   = 3'h2;
    localparam logic [2:0] REG_CNT_HI   = 3'h3;
    localparam logic [2:0] REG_CMPA_LO  = 3'h4;
    localparam logic [2:0] REG_CMPA_HI  = 3'h5;
    localparam logic [2:0] REG_CMPP_LO  = 3'h6;
    localparam logic [2:0] REG_CMPP_HI  = 3'h7;

    // Clock/run control fields
    localparam int B_PAUSE   = 7;
    localparam int B_CKS_HI  = 6;
    localparam int B_CKS_LO  = 4;
    localparam int B_RUN     = 3;
    // Mode/output control fields
    localparam int B_MODE_HI = 7;
    localparam int B_MODE_LO = 6;
    localparam int B_IOF_HI  = 5;
    localparam int B_IOF_LO  = 4;
    localparam int B_OC      = 3;
    localparam int B_POL     = 2;
    localparam int B_CAPSRC  = 1;
    localparam int B_CCLR    = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [9:0] CNT_MAX    = 10'h3ff;

    typedef enum logic [1:0] {
        PTC_MODE_CMP = 2'b00,
        PTC_MODE_CAP = 2'b01,
        PTC_MODE_PWM = 2'b10,
        PTC_MODE_TC  = 2'b11
    } ptc_mode_t;

    typedef enum logic [2:0] {
        PTC_CK_SYS4  = 3'b000,
        PTC_CK_SYS   = 3'b001,
        PTC_CK_HS16  = 3'b010,
        PTC_CK_HS64  = 3'b011,
        PTC_CK_TBC   = 3'b100,
        PTC_CK_NONE  = 3'b101,
        PTC_CK_EXTR  = 3'b110,
        PTC_CK_EXTF  = 3'b111
    } ptc_cksel_t;

    localparam logic [1:0] IOF_00 = 2'b00;
    localparam logic [1:0] IOF_01 = 2'b01;
    localparam logic [1:0] IOF_10 = 2'b10;
    localparam logic [1:0] IOF_11 = 2'b11;

endpackage

// file: hw/ptc_core.sv
// Behaviour
// - 10-bit up counter clocked by a selectable internal clock or external pin.
// - Two comparators match the counter against compare values A and P.
// - Software cannot load the counter; it can clear it only by a run-enable rise.
// - Counter clears on overflow or qualifying match, pulsing an event.
// - Pause bit holds the count; clearing it resumes from the held value.
// - Clock select: sys/4, sys, hs/16, hs/64, timebase, pin rise, pin fall.
// - Run-enable lets the counter run; clearing it stops counting.
// - Run-enable rise zeroes the counter; its fall keeps the residual value.
// - In compare mode a run-enable rise restores the initial output level.
// - Mode field: compare output, capture, PWM or single pulse, timer/counter.
// - Timer/counter mode ignores output function; module holds both pins low.
// - Compare mode A match: keep, drive low, drive high or toggle output.
// - PWM mode: force inactive, force active, PWM waveform, single pulse.
// - Capture mode edge: rising, falling, both, or capture disabled.
// - Compare mode: a match requesting the initial level shows no change.
// - Counter readable as low/high pair; compare A and P writable pairs.
// - Output control sets initial level, or active level in PWM modes.
// - Polarity bit inverts the output pin, except in timer/counter mode.
// - Clear select in compare and timer modes: A match clears, else P match or overflow when P zero.
// - Capture source: capture pin when 0, external clock pin when 1.
`timescale 1ns/1ps

module ptc_core (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        hs_clk_tick,
    input  wire logic        tbc_tick,
    input  wire logic        ext_count_clk_pin,
    input  wire logic        capture_in_pin,
    output logic             timer_out_pin,
    output logic             inverted_out_pin,
    output logic             match_a_evt,
    output logic             match_p_evt
);

    typedef struct packed {
        logic       pau;
        logic [2:0] cksel;
        logic       run;
        logic [1:0] mode;
        logic [1:0] iof;
        logic       oc;
        logic       pol;
        logic       capsrc;
        logic       cclr;
        logic [9:0] cnt;
        logic [9:0] cca;
        logic [9:0] ccp;
        logic [1:0] pre4;
        logic [5:0] preh;
        logic [2:0] ext_s;
        logic [2:0] cap_s;
        logic       ext_st;
        logic       cap_st;
        logic       out_lvl;
        logic       pin;
        logic       pin_n;
        logic [7:0] rdata;
        logic       evt_a;
        logic       evt_p;
    } ptc_state_t;

    ptc_state_t st_ff;
    ptc_state_t nxt_st;

    logic tick;
    logic a_hit;
    logic p_hit;
    logic run_rise;
    logic cap_evt;
    logic sel_tick;
    logic ext_rise;
    logic ext_fall;
    logic cap_rise;
    logic cap_fall;
    logic src_rise;
    logic src_fall;
    logic wr_c0;
    logic cnt_clr;

    always_comb begin
        nxt_st   = st_ff;
        nxt_st.evt_a = 1'b0;
        nxt_st.evt_p = 1'b0;
        nxt_st.rdata = 8'h00;

        nxt_st.ext_s = {st_ff.ext_s[1:0], ext_count_clk_pin};
        nxt_st.cap_s = {st_ff.cap_s[1:0], capture_in_pin};
        ext_rise = (st_ff.ext_s[1] == st_ff.ext_s[2]) && st_ff.ext_s[2] && !st_ff.ext_st;
        ext_fall = (st_ff.ext_s[1] == st_ff.ext_s[2]) && !st_ff.ext_s[2] && st_ff.ext_st;
        cap_rise = (st_ff.cap_s[1] == st_ff.cap_s[2]) && st_ff.cap_s[2] && !st_ff.cap_st;
        cap_fall = (st_ff.cap_s[1] == st_ff.cap_s[2]) && !st_ff.cap_s[2] && st_ff.cap_st;
        if (st_ff.ext_s[1] == st_ff.ext_s[2]) begin
            nxt_st.ext_st = st_ff.ext_s[2];
        end
        if (st_ff.cap_s[1] == st_ff.cap_s[2]) begin
            nxt_st.cap_st = st_ff.cap_s[2];
        end

        // Prescalers free-run so the first tick after start may be short
        nxt_st.pre4 = st_ff.pre4 + 2'd1;
        if (hs_clk_tick) begin
            nxt_st.preh = st_ff.preh + 6'd1;
        end

        case (ptc_pkg::ptc_cksel_t'(st_ff.cksel))
            ptc_pkg::PTC_CK_SYS4: sel_tick = (st_ff.pre4 == 2'd3);
            ptc_pkg::PTC_CK_SYS:  sel_tick = 1'b1;
            ptc_pkg::PTC_CK_HS16: sel_tick = hs_clk_tick && (st_ff.preh[3:0] == 4'hf);
            ptc_pkg::PTC_CK_HS64: sel_tick = hs_clk_tick && (st_ff.preh == 6'h3f);
            ptc_pkg::PTC_CK_TBC:  sel_tick = tbc_tick;
            ptc_pkg::PTC_CK_EXTR: sel_tick = ext_rise;
            ptc_pkg::PTC_CK_EXTF: sel_tick = ext_fall;
            default:              sel_tick = 1'b0;
        endcase

        // pause and run gate the tick
        tick = st_ff.run && !st_ff.pau && sel_tick;

        wr_c0    = reg_wr && (reg_addr == ptc_pkg::REG_CLK_RUN);
        run_rise = wr_c0 && reg_wdata[ptc_pkg::B_RUN] && !st_ff.run;

        // comparators; P of zero means a full 10-bit period
        a_hit = tick && (st_ff.cnt == st_ff.cca);
        p_hit = tick && ((st_ff.ccp == 10'h000) ? (st_ff.cnt == ptc_pkg::CNT_MAX)
                                                : (st_ff.cnt == st_ff.ccp));

        // clear select only in compare and timer modes
        case (ptc_pkg::ptc_mode_t'(st_ff.mode))
            ptc_pkg::PTC_MODE_CMP,
            // A of zero never clears, so the count wraps at full scale
            ptc_pkg::PTC_MODE_TC: cnt_clr = st_ff.cclr ? (a_hit && st_ff.cca != 10'h000) : p_hit;
            ptc_pkg::PTC_MODE_PWM: cnt_clr = (st_ff.iof == ptc_pkg::IOF_11) ? 1'b0 : p_hit;
            default:              cnt_clr = p_hit;
        endcase

        if (tick) begin
            nxt_st.cnt = cnt_clr ? 10'h000 : st_ff.cnt + 10'd1;
        end

        // events; A stays silent with A of zero outside capture
        if (st_ff.mode != ptc_pkg::PTC_MODE_CAP) begin
            nxt_st.evt_a = a_hit && (st_ff.cca != 10'h000);
        end
        nxt_st.evt_p = p_hit && !(st_ff.cclr && (st_ff.mode == ptc_pkg::PTC_MODE_CMP ||
                                                 st_ff.mode == ptc_pkg::PTC_MODE_TC));

        src_rise = st_ff.capsrc ? ext_rise : cap_rise;
        src_fall = st_ff.capsrc ? ext_fall : cap_fall;
        case (st_ff.iof)
            ptc_pkg::IOF_00: cap_evt = src_rise;
            ptc_pkg::IOF_01: cap_evt = src_fall;
            ptc_pkg::IOF_10: cap_evt = src_rise || src_fall;
            default:         cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt && st_ff.run && (st_ff.mode == ptc_pkg::PTC_MODE_CAP);

        // Single pulse ends on an A match
        if (st_ff.mode == ptc_pkg::PTC_MODE_PWM && st_ff.iof == ptc_pkg::IOF_11 && a_hit) begin
            nxt_st.run = 1'b0;
        end

        // register writes; count register has no write path
        if (reg_wr) begin
            case (reg_addr)
                ptc_pkg::REG_CLK_RUN: begin
                    nxt_st.pau   = reg_wdata[ptc_pkg::B_PAUSE];
                    nxt_st.cksel = reg_wdata[ptc_pkg::B_CKS_HI:ptc_pkg::B_CKS_LO];
                    nxt_st.run   = reg_wdata[ptc_pkg::B_RUN];
                end
                ptc_pkg::REG_MODE_OUT: begin
                    nxt_st.mode   = reg_wdata[ptc_pkg::B_MODE_HI:ptc_pkg::B_MODE_LO];
                    nxt_st.iof    = reg_wdata[ptc_pkg::B_IOF_HI:ptc_pkg::B_IOF_LO];
                    nxt_st.oc     = reg_wdata[ptc_pkg::B_OC];
                    nxt_st.pol    = reg_wdata[ptc_pkg::B_POL];
                    nxt_st.capsrc = reg_wdata[ptc_pkg::B_CAPSRC];
                    nxt_st.cclr   = reg_wdata[ptc_pkg::B_CCLR];
                end
                ptc_pkg::REG_CMPA_LO: nxt_st.cca[7:0] = reg_wdata;
                ptc_pkg::REG_CMPA_HI: nxt_st.cca[9:8] = reg_wdata[1:0];
                ptc_pkg::REG_CMPP_LO: nxt_st.ccp[7:0] = reg_wdata;
                ptc_pkg::REG_CMPP_HI: nxt_st.ccp[9:8] = reg_wdata[1:0];
                default: ;
            endcase
        end

        // Capture outranks a same-cycle software write to compare A
        if (cap_evt) begin
            nxt_st.cca   = st_ff.cnt;
            nxt_st.evt_a = 1'b1;
        end

        if (run_rise) begin
            nxt_st.cnt = 10'h000;
        end

        case (ptc_pkg::ptc_mode_t'(st_ff.mode))
            ptc_pkg::PTC_MODE_CMP: begin
                if (run_rise) begin
                    nxt_st.out_lvl = st_ff.oc;
                // A match action; equal level shows no change
                end else if (a_hit && st_ff.cca != 10'h000) begin
                    case (st_ff.iof)
                        ptc_pkg::IOF_01: nxt_st.out_lvl = 1'b0;
                        ptc_pkg::IOF_10: nxt_st.out_lvl = 1'b1;
                        ptc_pkg::IOF_11: nxt_st.out_lvl = !st_ff.out_lvl;
                        default:         nxt_st.out_lvl = st_ff.out_lvl;
                    endcase
                end
            end
            ptc_pkg::PTC_MODE_PWM: begin
                // active level given by output control
                case (st_ff.iof)
                    ptc_pkg::IOF_00: nxt_st.out_lvl = !st_ff.oc;
                    ptc_pkg::IOF_01: nxt_st.out_lvl = st_ff.oc;
                    ptc_pkg::IOF_10: nxt_st.out_lvl = (nxt_st.cnt < st_ff.cca) ? st_ff.oc : !st_ff.oc;
                    default:         nxt_st.out_lvl = nxt_st.run ? st_ff.oc : !st_ff.oc;
                endcase
            end
            default: nxt_st.out_lvl = st_ff.out_lvl;
        endcase

        // timer/counter mode leaves both pins low
        if (nxt_st.mode == ptc_pkg::PTC_MODE_TC) begin
            nxt_st.pin   = 1'b0;
            nxt_st.pin_n = 1'b0;
        end else begin
            nxt_st.pin   = nxt_st.out_lvl ^ nxt_st.pol;
            nxt_st.pin_n = !(nxt_st.out_lvl ^ nxt_st.pol);
        end

        // register reads, data in the following cycle only
        if (reg_rd) begin
            case (reg_addr)
                ptc_pkg::REG_CLK_RUN:  nxt_st.rdata = {st_ff.pau, st_ff.cksel, st_ff.run, 3'h0};
                ptc_pkg::REG_MODE_OUT: nxt_st.rdata = {st_ff.mode, st_ff.iof, st_ff.oc,
                                                       st_ff.pol, st_ff.capsrc, st_ff.cclr};
                ptc_pkg::REG_CNT_LO:   nxt_st.rdata = st_ff.cnt[7:0];
                ptc_pkg::REG_CNT_HI:   nxt_st.rdata = {6'h00, st_ff.cnt[9:8]};
                ptc_pkg::REG_CMPA_LO:  nxt_st.rdata = st_ff.cca[7:0];
                ptc_pkg::REG_CMPA_HI:  nxt_st.rdata = {6'h00, st_ff.cca[9:8]};
                ptc_pkg::REG_CMPP_LO:  nxt_st.rdata = st_ff.ccp[7:0];
                default:               nxt_st.rdata = {6'h00, st_ff.ccp[9:8]};
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata        = st_ff.rdata;
    assign timer_out_pin    = st_ff.pin;
    assign inverted_out_pin = st_ff.pin_n;
    assign match_a_evt      = st_ff.evt_a;
    assign match_p_evt      = st_ff.evt_p;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_stopped2;
        !st_ff.run ##1 !st_ff.run;
    endsequence

    sequence s_paused2;
        // A run-enable rise still zeroes a paused count
        (st_ff.pau && !run_rise) ##1 st_ff.pau;
    endsequence

    a_run_rise_clear: assert property (
        run_rise |=> (st_ff.cnt == 10'h000) && st_ff.run)
        else $error("count not zero after run-enable rise");

    a_stop_hold: assert property (
        s_stopped2 |-> $stable(st_ff.cnt))
        else $error("count moved while stopped");

    a_pause_hold: assert property (
        s_paused2 |-> $stable(st_ff.cnt))
        else $error("count moved while paused");

    a_ck_none_hold: assert property (
        (st_ff.cksel == ptc_pkg::PTC_CK_NONE && !run_rise) ##1 (st_ff.cksel == ptc_pkg::PTC_CK_NONE)
        |-> $stable(st_ff.cnt))
        else $error("count moved with reserved clock select");

    a_count_step: assert property (
        (tick && !cnt_clr && !run_rise) |=> st_ff.cnt == $past(st_ff.cnt) + 10'd1)
        else $error("count did not step by one");

    a_p_match_clear: assert property (
        (p_hit && !st_ff.cclr && st_ff.mode == 2'b00 && !run_rise) |=> st_ff.cnt == 10'h000 ##0 match_p_evt)
        else $error("P match did not clear and signal");

    a_cmp_init_lvl: assert property (
        (run_rise && st_ff.mode == ptc_pkg::PTC_MODE_CMP) |=> st_ff.out_lvl == $past(st_ff.oc))
        else $error("initial level not restored");

    a_cmp_set_high: assert property (
        (a_hit && st_ff.cca != 10'h000 && st_ff.mode == 2'b00 && st_ff.iof == 2'b10 && !run_rise)
        |=> st_ff.out_lvl && match_a_evt)
        else $error("A match did not drive output high");

    a_cap_latch: assert property (
        cap_evt |=> (st_ff.cca == $past(st_ff.cnt)) && match_a_evt)
        else $error("capture did not latch count");

    a_tc_pins_low: assert property (
        (st_ff.mode == 2'b11)[*2] |-> !timer_out_pin && !inverted_out_pin)
        else $error("pins driven in timer mode");

    a_rd_count: assert property (
        (reg_rd && reg_addr == 3'h2) |=> reg_rdata == $past(st_ff.cnt[7:0]))
        else $error("count low byte read wrong");

endmodule // ptc_core

// file: test/ptc_pin_model.sv
`timescale 1ns/1ps

module ptc_pin_model (
    output logic ext_count_clk_pin,
    output logic capture_in_pin
);
    // Pins idle low; half-ns steps keep every edge off a rising system clock edge
    initial begin
        ext_count_clk_pin = 1'b0;
        capture_in_pin    = 1'b0;
    end

    task automatic pulses(input int n);
        repeat (n) begin
            #63.5 ext_count_clk_pin = 1'b1;
            #63.5 ext_count_clk_pin = 1'b0;
        end
    endtask

    task automatic pulse(input logic on_clk_pin);
        #32;
        if (on_clk_pin) begin
            pulses(1);
        end else begin
            capture_in_pin = 1'b1;
            #63.5 capture_in_pin = 1'b0;
        end
    endtask
endmodule // ptc_pin_model

// file: test/ptc_core_tb.sv
`timescale 1ns/1ps

module ptc_core_tb;
    logic        sys_clk     = 1'b0;
    logic        resetn      = 1'b0;
    logic [2:0]  reg_addr    = 3'h0;
    logic [7:0]  reg_wdata   = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic        hs_clk_tick = 1'b0;
    logic        tbc_tick    = 1'b0;
    logic [7:0]  reg_rdata;
    logic        ext_count_clk_pin;
    logic        capture_in_pin;
    logic        timer_out_pin;
    logic        inverted_out_pin;
    logic        match_a_evt;
    logic        match_p_evt;
    int          errors      = 0;
    int          comparisons = 0;
    logic [15:0] cycles      = 16'h0;

    ptc_core ptc_core_i (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hs_clk_tick(hs_clk_tick), .tbc_tick(tbc_tick),
        .ext_count_clk_pin(ext_count_clk_pin), .capture_in_pin(capture_in_pin), .timer_out_pin(timer_out_pin),
        .inverted_out_pin(inverted_out_pin), .match_a_evt(match_a_evt), .match_p_evt(match_p_evt));
    ptc_pin_model ptc_pin_model_i (.ext_count_clk_pin(ext_count_clk_pin), .capture_in_pin(capture_in_pin));

    always #5 sys_clk = ~sys_clk;

    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // High-speed tick every 2nd cycle, timebase tick every 8th
    always @(posedge sys_clk) begin
        cycles      <= cycles + 16'h1;
        hs_clk_tick <= ~hs_clk_tick;
        tbc_tick    <= (cycles[2:0] == 3'h6);
        if (cycles == 16'd30000) begin
            errors++;
            stop_test();
        end
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, lo);
        end
    endtask

    // Sel: 0 out pin, 1 P event, 2 A event, 3 inverted pin
    task automatic cnt(input int sel, input int cyc, output logic [15:0] n);
        n = 16'h0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            n += {15'h0, (sel == 0) ? timer_out_pin : (sel == 1) ? match_p_evt :
                         (sel == 2) ? match_a_evt : inverted_out_pin};
        end
    endtask

    // Cycles between two consecutive events
    task automatic gap(input logic use_p, output logic [15:0] n);
        int k;
        k = 0;
        n = 16'h0;
        do begin @(posedge sys_clk); #1; k++; end while ((use_p ? match_p_evt : match_a_evt) !== 1'b1 && k < 2000);
        do begin @(posedge sys_clk); #1; n++; end while ((use_p ? match_p_evt : match_a_evt) !== 1'b1 && n < 2000);
    endtask

    initial begin
        logic [7:0]  v;
        logic [7:0]  w;
        logic [15:0] n;
        logic [7:0]  ck  [5] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48};
        int          ex  [5] = '{50, 201, 6, 1, 25};
        logic [7:0]  cm  [7] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h19, 8'h29, 8'h25};
        logic [1:0]  ci  [7] = '{2'b10, 2'b10, 2'b10, 2'b10, 2'b01, 2'b01, 2'b01};
        logic [1:0]  ca  [7] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b10, 2'b01, 2'b10};
        logic [7:0]  cp  [6] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h42, 8'h42};
        logic        cx  [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        int          ce  [6] = '{1, 1, 2, 0, 1, 0};
        int          pe  [3] = '{0, 90, 30};
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) begin rd(a[2:0], v); chk(v, 0, 0); end
        wr(3'h2, 8'hff);
        wr(3'h3, 8'hff);
        rd(3'h2, v); chk(v, 0, 0);
        rd(3'h3, v); chk(v, 0, 0);
        wr(3'h5, 8'hff);
        rd(3'h5, v); chk(v, 8'h03, 8'h03);
        wr(3'h5, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(3'h0, 8'h00);
            wr(3'h0, ck[i]);
            repeat (200) @(posedge sys_clk);
            rd(3'h2, v); chk(v, ex[i] - (ex[i] > 2 ? 2 : ex[i]), ex[i] + 2);
        end
        for (int i = 0; i < 2; i++) begin
            wr(3'h0, 8'h00);
            wr(3'h0, i ? 8'h78 : 8'h68);
            ptc_pin_model_i.pulses(5);
            repeat (8) @(posedge sys_clk);
            rd(3'h2, v); chk(v, 5, 5);
        end
        wr(3'h0, 8'h00);
        wr(3'h0, 8'h18);
        repeat (20) @(posedge sys_clk);
        wr(3'h0, 8'h98);
        rd(3'h2, v);
        repeat (10) @(posedge sys_clk);
        rd(3'h2, w); chk(w, v, v);
        wr(3'h0, 8'h18);
        rd(3'h2, w); chk(w, v + 1, v + 3);
        wr(3'h0, 8'h10);
        rd(3'h2, v);
        repeat (10) @(posedge sys_clk);
        rd(3'h2, w); chk(w, v, v);
        wr(3'h0, 8'h18);
        rd(3'h2, w); chk(w, 0, 2);
        repeat (10) @(posedge sys_clk);
        wr(3'h0, 8'h58);
        rd(3'h2, v);
        repeat (10) @(posedge sys_clk);
        rd(3'h2, w); chk(w, v, v);
        wr(3'h0, 8'h00);
        wr(3'h6, 8'h03);
        wr(3'h0, 8'h18);
        gap(1'b1, n); chk(n, 4, 4);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h05);
        wr(3'h1, 8'h01);
        wr(3'h0, 8'h18);
        gap(1'b0, n); chk(n, 6, 6);
        cnt(1, 50, n); chk(n, 0, 0);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h6, 8'h00);
        wr(3'h0, 8'h18);
        gap(1'b1, n); chk(n, 1024, 1024);
        for (int i = 0; i < 7; i++) begin
            wr(3'h0, 8'h00);
            wr(3'h1, cm[i]);
            wr(3'h0, 8'h18);
            repeat (2) @(posedge sys_clk);
            #1 chk({inverted_out_pin, timer_out_pin}, ci[i], ci[i]);
            repeat (7) @(posedge sys_clk);
            #1 chk({inverted_out_pin, timer_out_pin}, ca[i], ca[i]);
        end
        wr(3'h4, 8'h03);
        wr(3'h6, 8'h08);
        for (int i = 0; i < 3; i++) begin
            wr(3'h0, 8'h00);
            wr(3'h1, 8'h88 + 8'h10 * i[7:0]);
            wr(3'h0, 8'h18);
            repeat (20) @(posedge sys_clk);
            cnt(0, 90, n); chk(n, pe[i] - (pe[i] > 0), pe[i] + (pe[i] < 90));
        end
        wr(3'h0, 8'h00);
        wr(3'h1, 8'hb8);
        wr(3'h0, 8'h18);
        cnt(0, 40, n); chk(n, 2, 6);
        rd(3'h0, v); chk(v[3], 0, 0);
        wr(3'h6, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(3'h0, 8'h00);
            wr(3'h1, cp[i]);
            wr(3'h0, 8'h18);
            repeat (10) @(posedge sys_clk);
            fork
                ptc_pin_model_i.pulse(cx[i]);
                cnt(2, 40, n);
            join
            chk(n, ce[i], ce[i]);
            if (i == 0) begin rd(3'h4, v); chk(v, 8, 30); end
        end
        wr(3'h0, 8'h00);
        wr(3'h6, 8'h03);
        wr(3'h1, 8'hc4);
        wr(3'h0, 8'h18);
        cnt(0, 30, n); chk(n, 0, 0);
        cnt(3, 30, n); chk(n, 0, 0);
        gap(1'b1, n); chk(n, 4, 4);
        stop_test();
    end
endmodule // ptc_core_tb
